// [common/pwm_timer_params.svh]
`ifndef PWM_TIMER_PARAMS_SVH
`define PWM_TIMER_PARAMS_SVH
`define PWM_ADDR_W       12
`define PWM_CTRL_OFS     12'h000
`define PWM_COUNT_OFS    12'h004
`define PWM_PRESC_OFS    12'h008
`define PWM_PCOUNT_OFS   12'h00C
`define PWM_MCTRL_OFS    12'h010
`define PWM_OCTRL_OFS    12'h014
`define PWM_RELEASE_OFS  12'h018
`define PWM_ISTAT_OFS    12'h01C
`define PWM_IMASK_OFS    12'h020
`define PWM_MATCH_OFS    12'h040
`define PWM_MATCH_LAST   12'h058
`define PWM_CTRL_EN_BIT   0
`define PWM_CTRL_RST_BIT  1
`define PWM_CTRL_MODE_BIT 2
`define PWM_OCTRL_EN_POS  8
`define PWM_MACT_W        3
`define PWM_ZERO32        32'h0000_0000
`define PWM_ONE32         32'h0000_0001
`endif

// [common/pwm_timer_pkg.sv]
package pwm_timer_pkg;
  // per-match action bits, low to high: irq, reset, stop
  typedef struct packed {
    logic stop;
    logic rst;
    logic irq;
  } match_action_type;
endpackage

// [design/timer_based_pwm_generator.sv]
// What this block does
// - a 32-bit count driven by a 32-bit programmable prescaler is the time base of every output.
// - the count advances on pclk cycles and can raise interrupts or act when it reaches set values.
// - seven match values serve up to six single-edge or three double-edge outputs or a mix.
// - a cycle-period match clears the count and so fixes the output repetition rate.
// - a single-edge output rises at each cycle-period match and falls on its own match.
// - a single-edge output programmed constantly low stays low all cycle with no rise.
// - a double-edge output rises on one match and falls on another, giving either pulse polarity.
// - all outputs share one rate, costing one extra match per single-edge and two per double-edge.
// - each match can continue, stop or reset the count, each with an optional interrupt.
// - period and width can be any whole count within the counter width.
// - new match values stay inactive until software releases them and then apply glitch free.
// - with pulse mode off the block is a plain timer whose matches drive no outputs.
`include "pwm_timer_params.svh"
`timescale 1ns/1ps
`default_nettype none
module timer_based_pwm_generator #(
  parameter int NUM_MATCH = 7,
  parameter int NUM_OUT   = 6
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`PWM_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic      [NUM_OUT-1:0]     pwm_out,
  output logic                        irq
);
  localparam int MW = NUM_MATCH * `PWM_MACT_W;

  function automatic pwm_timer_pkg::match_action_type action_of(input logic [MW-1:0] m,
                                                                 input int i);
    action_of = pwm_timer_pkg::match_action_type'(m[i*`PWM_MACT_W +: `PWM_MACT_W]);
  endfunction

  logic [31:0]          count;
  logic [31:0]          pcount;
  logic [31:0]          presc;
  logic                 run_en;
  logic                 count_clr;
  logic                 pwm_mode;
  logic [MW-1:0]        mctrl;
  logic [NUM_OUT-1:0]   dbl_sel;
  logic [NUM_OUT-1:0]   out_en;
  logic [NUM_MATCH-1:0] release_bits;
  logic [NUM_MATCH-1:0] int_stat;
  logic [NUM_MATCH-1:0] int_mask;
  logic [31:0]          shadow [NUM_MATCH];
  logic [31:0]          active [NUM_MATCH];

  // bus decode
  wire setup_ph = psel & ~penable;
  wire access   = psel & penable;
  wire wr       = access & pwrite;
  wire rd_stat  = access & ~pwrite & (paddr == `PWM_ISTAT_OFS);
  wire in_match = (paddr >= `PWM_MATCH_OFS) && (paddr <= `PWM_MATCH_LAST) && (paddr[1:0] == 2'h0);
  wire [2:0] match_idx = 3'((paddr - `PWM_MATCH_OFS) >> 2);
  wire mapped   = in_match || paddr == `PWM_CTRL_OFS || paddr == `PWM_COUNT_OFS
                  || paddr == `PWM_PRESC_OFS || paddr == `PWM_PCOUNT_OFS
                  || paddr == `PWM_MCTRL_OFS || paddr == `PWM_OCTRL_OFS
                  || paddr == `PWM_RELEASE_OFS || paddr == `PWM_ISTAT_OFS
                  || paddr == `PWM_IMASK_OFS;
  wire wr_ctrl  = wr & (paddr == `PWM_CTRL_OFS);
  wire wr_rel   = wr & (paddr == `PWM_RELEASE_OFS);

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // time base
  wire tick = run_en & ~count_clr & (pcount == presc);

  logic [NUM_MATCH-1:0] hit;
  logic [NUM_MATCH-1:0] rst_req;
  logic [NUM_MATCH-1:0] stop_req;
  logic [NUM_MATCH-1:0] irq_req;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MATCH; gi++)
    begin : g_match
      wire pwm_timer_pkg::match_action_type act = action_of(mctrl, gi);
      // a match compares the full 32-bit count, so any value is legal
      assign hit[gi]      = tick & (count == active[gi]);
      assign rst_req[gi]  = hit[gi] & act.rst;
      assign stop_req[gi] = hit[gi] & act.stop;
      assign irq_req[gi]  = hit[gi] & act.irq;
    end
  endgenerate

  wire cycle_start = pwm_mode & hit[0];
  wire reset_hit   = (|rst_req) | cycle_start;
  wire stop_hit    = |stop_req;
  // in pulse mode copies wait for the period boundary; as a plain timer they apply at once
  wire [NUM_MATCH-1:0] apply = pwm_mode ? (cycle_start ? release_bits : '0) : release_bits;

  wire [31:0] next_pcount = (count_clr | tick) ? `PWM_ZERO32 : pcount + `PWM_ONE32;
  wire [31:0] next_count  = count_clr ? `PWM_ZERO32 :
                            reset_hit ? `PWM_ZERO32 :
                            stop_hit ? count :
                            tick ? count + `PWM_ONE32 : count;
  // software set of a release bit wins over the hardware clear
  wire [NUM_MATCH-1:0] next_release = (release_bits & ~apply)
                                    | (wr_rel ? pwdata[NUM_MATCH-1:0] : '0);
  wire [NUM_MATCH-1:0] stat_clr = rd_stat ? prdata[NUM_MATCH-1:0] : '0;
  wire [NUM_MATCH-1:0] next_stat = (int_stat & ~stat_clr) | irq_req;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pcount <= `PWM_ZERO32;
      count  <= `PWM_ZERO32;
    end
    else if (run_en | count_clr)
    begin
      pcount <= next_pcount;
      count  <= next_count;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_en    <= 1'b0;
      count_clr <= 1'b0;
      pwm_mode  <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        count_clr <= pwdata[`PWM_CTRL_RST_BIT];
        pwm_mode  <= pwdata[`PWM_CTRL_MODE_BIT];
      end
      if (stop_hit)
        run_en <= 1'b0;
      else if (wr_ctrl)
        run_en <= pwdata[`PWM_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc        <= `PWM_ZERO32;
      mctrl        <= '0;
      dbl_sel      <= '0;
      out_en       <= '0;
      int_mask     <= '0;
      release_bits <= '0;
      int_stat     <= '0;
    end
    else
    begin
      if (wr && paddr == `PWM_PRESC_OFS)
        presc <= pwdata;
      if (wr && paddr == `PWM_MCTRL_OFS)
        mctrl <= pwdata[MW-1:0];
      if (wr && paddr == `PWM_OCTRL_OFS)
      begin
        // output 1 has no lower match to rise on, so it is single-edge only
        dbl_sel <= {pwdata[NUM_OUT-1:1], 1'b0};
        out_en  <= pwdata[`PWM_OCTRL_EN_POS +: NUM_OUT];
      end
      if (wr && paddr == `PWM_IMASK_OFS)
        int_mask <= pwdata[NUM_MATCH-1:0];
      release_bits <= next_release;
      int_stat     <= next_stat;
    end
  end

  generate
    for (gi = 0; gi < NUM_MATCH; gi++)
    begin : g_regs
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          shadow[gi] <= `PWM_ZERO32;
          active[gi] <= `PWM_ZERO32;
        end
        else
        begin
          if (wr && in_match && match_idx == 3'(gi))
            shadow[gi] <= pwdata;
          if (apply[gi])
            active[gi] <= shadow[gi];
        end
      end
    end
  endgenerate

  // pulse outputs; one match per single-edge output, two per double-edge
  generate
    for (gi = 1; gi <= NUM_OUT; gi++)
    begin : g_out
      wire rise = dbl_sel[gi-1] ? hit[gi-1] : hit[0];
      wire fall = hit[gi];
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          pwm_out[gi-1] <= 1'b0;
        else if (!pwm_mode || !out_en[gi-1])
          pwm_out[gi-1] <= 1'b0;
        else if (fall)
          pwm_out[gi-1] <= 1'b0;
        else if (rise)
          pwm_out[gi-1] <= 1'b1;
      end
    end
  endgenerate

  // read data captured in the setup phase
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = `PWM_ZERO32;
    case (paddr)
      `PWM_CTRL_OFS:    rd_mux = {29'h0000_0000, pwm_mode, count_clr, run_en};
      `PWM_COUNT_OFS:   rd_mux = count;
      `PWM_PRESC_OFS:   rd_mux = presc;
      `PWM_PCOUNT_OFS:  rd_mux = pcount;
      `PWM_MCTRL_OFS:   rd_mux = 32'(mctrl);
      `PWM_OCTRL_OFS:   rd_mux = 32'({out_en, 2'h0, dbl_sel});
      `PWM_RELEASE_OFS: rd_mux = 32'(release_bits);
      `PWM_ISTAT_OFS:   rd_mux = 32'(int_stat);
      `PWM_IMASK_OFS:   rd_mux = 32'(int_mask);
      default:          rd_mux = in_match ? shadow[match_idx] : `PWM_ZERO32;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= `PWM_ZERO32;
    else if (setup_ph)
      prdata <= pwrite ? `PWM_ZERO32 : rd_mux;
  end

  assign irq = |(int_stat & int_mask);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cycle_start;
    pwm_mode && hit[0];
  endsequence
  sequence s_single_rise;
    pwm_mode && out_en[0] && hit[0] && !hit[1];
  endsequence

  property p_prescale;
    tick |=> pcount == `PWM_ZERO32;
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler did not restart");

  property p_count_inc;
    tick && !reset_hit && !stop_hit && !count_clr |=> count == $past(count) + `PWM_ONE32;
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("count did not advance");

  property p_period;
    s_cycle_start |=> count == `PWM_ZERO32;
  endproperty
  a_period: assert property (p_period) else $error("period match did not clear count");

  property p_rise;
    s_single_rise |=> pwm_out[0];
  endproperty
  a_rise: assert property (p_rise) else $error("single-edge output did not rise");

  property p_fall;
    hit[1] |=> !pwm_out[0];
  endproperty
  a_fall: assert property (p_fall) else $error("single-edge output did not fall");

  property p_const_low;
    !out_en[2] |=> !pwm_out[2];
  endproperty
  a_const_low: assert property (p_const_low) else $error("disabled output not low");

  property p_double;
    pwm_mode && out_en[1] && dbl_sel[1] && hit[1] && !hit[2] |=> pwm_out[1];
  endproperty
  a_double: assert property (p_double) else $error("double-edge output did not rise");

  property p_stop;
    stop_hit && !reset_hit |=> !run_en && count == $past(count) ##1 $stable(count);
  endproperty
  a_stop: assert property (p_stop) else $error("stop match did not halt count");

  property p_hold;
    !apply[1] |=> active[1] == $past(active[1]);
  endproperty
  a_hold: assert property (p_hold) else $error("unreleased match value applied");

  property p_apply;
    s_cycle_start ##0 release_bits[1] |=> active[1] == $past(shadow[1]);
  endproperty
  a_apply: assert property (p_apply) else $error("released value not applied");

  property p_timer_mode;
    !pwm_mode |=> pwm_out == '0;
  endproperty
  a_timer_mode: assert property (p_timer_mode) else $error("output driven in timer mode");
endmodule
`default_nettype wire

// [tb/timer_based_pwm_generator_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module timer_based_pwm_generator_bench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  pwm_out;
  logic        irq;
  int          errors;
  int          checks_done;
  int          cycles;
  logic [31:0] rv;
  logic        re;
  int          hi [6];

  timer_based_pwm_generator u_dut (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .pwm_out (pwm_out),
    .irq     (irq)
  );

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rv, exp);
  endtask

  // count high cycles of every output over n clocks
  task automatic measure(input int n);
    for (int k = 0; k < 6; k++) hi[k] = 0;
    repeat (n)
    begin
      @(negedge pclk);
      for (int k = 0; k < 6; k++) hi[k] += int'(pwm_out[k]);
    end
  endtask

  task automatic wait_release();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, 12'h018, 32'h0000_0000);
      n++;
    end
    while (rv[6:0] != 7'h00 && n < 50);
    chk("release_cleared", rv, 32'h0000_0000);
  endtask

  task automatic test_reset_and_map();
    rd_chk("ctrl_reset", 12'h000, 32'h0000_0000);
    rd_chk("match0_reset", 12'h040, 32'h0000_0000);
    chk("mapped_err", {31'h0, re}, 32'h0000_0000);
    chk("ready_level", {31'h0, pready}, 32'h0000_0001);
    rd_chk("unmapped_data", 12'h030, 32'h0000_0000);
    chk("unmapped_err", {31'h0, re}, 32'h0000_0001);
  endtask

  task automatic test_timer_stop_irq();
    logic seen_out;
    seen_out = 1'b0;
    wr(12'h008, 32'h0000_0002);
    wr(12'h044, 32'h0000_0005);
    wr(12'h010, 32'h0000_0028);
    wr(12'h018, 32'h0000_0002);
    wr(12'h020, 32'h0000_0000);
    wr(12'h014, 32'h0000_3F00);
    wr(12'h000, 32'h0000_0001);
    repeat (40)
    begin
      @(negedge pclk);
      seen_out = seen_out | (|pwm_out);
    end
    chk("timer_mode_out", {31'h0, seen_out}, 32'h0000_0000);
    rd_chk("count_stopped", 12'h004, 32'h0000_0005);
    rd_chk("run_cleared", 12'h000, 32'h0000_0000);
    chk("irq_masked", {31'h0, irq}, 32'h0000_0000);
    wr(12'h020, 32'h0000_0002);
    @(negedge pclk);
    chk("irq_unmasked", {31'h0, irq}, 32'h0000_0001);
    rd_chk("status_read", 12'h01C, 32'h0000_0002);
    @(negedge pclk);
    chk("irq_after_clear", {31'h0, irq}, 32'h0000_0000);
    rd_chk("status_cleared", 12'h01C, 32'h0000_0000);
  endtask

  task automatic test_pulse_outputs();
    wr(12'h000, 32'h0000_0002);
    rd_chk("count_held", 12'h004, 32'h0000_0000);
    wr(12'h010, 32'h0000_0000);
    wr(12'h020, 32'h0000_0000);
    wr(12'h008, 32'h0000_0000);
    wr(12'h040, 32'h0000_0009);
    wr(12'h044, 32'h0000_0003);
    wr(12'h048, 32'h0000_0005);
    wr(12'h04C, 32'h0000_0007);
    // outputs 1 and 3 enabled, output 3 double edge, output 2 constant low
    wr(12'h014, 32'h0000_0504);
    wr(12'h018, 32'h0000_000F);
    wr(12'h000, 32'h0000_0005);
    wait_release();
    repeat (10) @(posedge pclk);
    measure(20);
    chk("single_edge_high", hi[0], 8);
    chk("const_low_high", hi[1], 0);
    chk("double_edge_high", hi[2], 4);
    chk("unused_out_high", hi[3] + hi[4] + hi[5], 0);
    wr(12'h044, 32'h0000_0006);
    repeat (30) @(posedge pclk);
    measure(20);
    chk("unreleased_width", hi[0], 8);
    wr(12'h018, 32'h0000_0002);
    wait_release();
    repeat (10) @(posedge pclk);
    measure(20);
    chk("released_width", hi[0], 14);
    chk("double_after_release", hi[2], 4);
    // rise match after fall match gives a negative going pulse
    wr(12'h048, 32'h0000_0008);
    wr(12'h018, 32'h0000_0004);
    wait_release();
    repeat (10) @(posedge pclk);
    measure(20);
    chk("negative_pulse_high", hi[2], 18);
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      final_report();
    end
  end

  initial
  begin
    errors = 0;
    checks_done = 0;
    cycles = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    test_reset_and_map();
    test_timer_stop_irq();
    test_pulse_outputs();
    final_report();
  end
endmodule
`default_nettype wire
